// [logic/brc_reset_ctrl.sv]
/*
  Reset controller with optional bidirectional reset pin, filter, flags and config capture.
  Assumes pins arrive asynchronously and the pin is wired-low (open drain) outside.
*/
`timescale 1ns/1ns
`default_nettype none
module brc_reset_ctrl
  import brc_pkg::*;
#(
  parameter int SEQ_CYCLES = SEQ_CYC_DEF
) (
  input  wire logic                 ref_clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 clk_en_i,
  input  wire logic                 osc_running_i,
  input  wire logic                 reset_input_pin_i,
  input  wire logic                 ext_access_n_i,
  input  wire logic [CONFIG_SAMPLE_PORT_ZERO_W-1:0]   config_sample_port_zero_i,
  input  wire logic                 sw_reset_req_i,
  input  wire logic                 watchdog_reset_i,
  input  wire logic                 end_of_init_instruction_i,
  input  wire logic                 bidir_enable_wr_i,
  input  wire logic                 bidir_enable_wdata_i,
  output logic                      reset_input_pin_o,
  output logic                      reset_input_pin_oe_o,
  output logic                      core_reset_o,
  output logic                      bidir_reset_enable_o,
  output logic                      init_done_o,
  output logic [FLAG_W-1:0]         reset_flags_o,
  output logic [CONFIG_SAMPLE_PORT_ZERO_W-1:0]        port_zero_cfg_o,
  output logic                      boot_loader_o
);

  // Synchronisers: three stages, a change counts when stages two and three agree
  logic [2:0]         pin_sync_r;
  logic [2:0]         ea_sync_r;
  logic [CONFIG_SAMPLE_PORT_ZERO_W-1:0] p0_s1_r, p0_s2_r, p0_s3_r;
  logic               pin_low_r, pin_low_nxt;
  logic               ea_n_r, ea_n_nxt;
  logic [CONFIG_SAMPLE_PORT_ZERO_W-1:0] p0_r, p0_nxt;
  logic [FILT_W-1:0]  filt_cnt_r, filt_cnt_nxt;
  logic               pin_seen_r, pin_seen_nxt;

  always_comb begin
    pin_low_nxt  = pin_low_r;
    ea_n_nxt     = ea_n_r;
    p0_nxt       = p0_r;
    filt_cnt_nxt = filt_cnt_r;
    pin_seen_nxt = pin_seen_r;
    if (pin_sync_r[1] == pin_sync_r[2]) begin
      pin_low_nxt = ~pin_sync_r[2];
    end
    if (ea_sync_r[1] == ea_sync_r[2]) begin
      ea_n_nxt = ea_sync_r[2];
    end
    if (p0_s2_r == p0_s3_r) begin
      p0_nxt = p0_s3_r;
    end
    // Spike filter: low must persist past the spike time before it counts
    if (!pin_low_r) begin
      filt_cnt_nxt = '0;
      pin_seen_nxt = 1'b0;
    end else if (filt_cnt_r < FILT_W'(FILT_CYC)) begin
      filt_cnt_nxt = filt_cnt_r + FILT_W'(1);
    end else begin
      pin_seen_nxt = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pin_sync_r <= 3'h7;
      ea_sync_r  <= 3'h7;
      p0_s1_r    <= '0;
      p0_s2_r    <= '0;
      p0_s3_r    <= '0;
      pin_low_r  <= 1'b0;
      ea_n_r     <= 1'b1;
      p0_r       <= '0;
      filt_cnt_r <= '0;
      pin_seen_r <= 1'b0;
    end else if (clk_en_i) begin
      pin_sync_r <= {pin_sync_r[1:0], reset_input_pin_i};
      ea_sync_r  <= {ea_sync_r[1:0], ext_access_n_i};
      p0_s1_r    <= config_sample_port_zero_i;
      p0_s2_r    <= p0_s1_r;
      p0_s3_r    <= p0_s2_r;
      pin_low_r  <= pin_low_nxt;
      ea_n_r     <= ea_n_nxt;
      p0_r       <= p0_nxt;
      filt_cnt_r <= filt_cnt_nxt;
      pin_seen_r <= pin_seen_nxt;
    end
  end

  // Reset sequencer
  brc_state_type      state_r, state_nxt;
  logic [CNT_W-1:0]   cnt_r, cnt_nxt;
  logic [1:0]         cause_r, cause_nxt;
  logic               bidir_act_r, bidir_act_nxt;
  logic               bidir_en_r, bidir_en_nxt;
  logic               init_done_r, init_done_nxt;
  logic               long_r, long_nxt;
  logic [FLAG_W-1:0]  flags_r, flags_nxt;
  logic [CONFIG_SAMPLE_PORT_ZERO_W-1:0] cfg_r, cfg_nxt;
  logic               boot_r, boot_nxt;
  logic               drive_r, drive_nxt;
  logic               core_rst_r, core_rst_nxt;
  logic               hw_req;
  logic               seq_done;

  // Seen lags the pin by a cycle: after our own drive ends it must not restart a reset
  assign hw_req   = pin_seen_r & pin_low_r & osc_running_i;
  assign seq_done = (cnt_r == '0);

  always_comb begin
    state_nxt     = state_r;
    cnt_nxt       = cnt_r;
    cause_nxt     = cause_r;
    bidir_act_nxt = bidir_act_r;
    bidir_en_nxt  = bidir_en_r;
    init_done_nxt = init_done_r;
    long_nxt      = long_r;
    flags_nxt     = flags_r;
    cfg_nxt       = cfg_r;
    boot_nxt      = boot_r;
    unique case (state_r)
      ST_RUN: begin
        if (end_of_init_instruction_i) begin
          init_done_nxt = 1'b1;
        end
        if (bidir_enable_wr_i && !init_done_r) begin
          bidir_en_nxt = bidir_enable_wdata_i;
        end
        if (hw_req || sw_reset_req_i || watchdog_reset_i) begin
          // Hardware cause wins when several arrive together
          state_nxt     = ST_SEQ;
          cnt_nxt       = CNT_W'(SEQ_CYCLES - 1);
          cause_nxt     = hw_req ? CAUSE_HW : (sw_reset_req_i ? CAUSE_SW : CAUSE_WDT);
          bidir_act_nxt = bidir_en_r;
          bidir_en_nxt  = 1'b0;
          init_done_nxt = 1'b0;
          long_nxt      = 1'b0;
        end
      end
      ST_SEQ: begin
        if (!seq_done) begin
          cnt_nxt = cnt_r - CNT_W'(1);
        end
        // Without bidirectional mode a short pin reset ends with the pin
        if (cause_r == CAUSE_HW && !bidir_act_r && !pin_low_r && !pin_seen_r) begin
          state_nxt = ST_REL;
          cnt_nxt   = CNT_W'(RELEASE_CYC - 1);
        end else if (seq_done) begin
          if (cause_r == CAUSE_HW && pin_seen_r && !bidir_act_r) begin
            state_nxt = ST_HOLD;
            long_nxt  = 1'b1;
          end else begin
            state_nxt = ST_REL;
            cnt_nxt   = CNT_W'(RELEASE_CYC - 1);
          end
        end
      end
      ST_HOLD: begin
        if (!pin_low_r) begin
          state_nxt = ST_REL;
          cnt_nxt   = CNT_W'(RELEASE_CYC - 1);
        end
      end
      ST_REL: begin
        // Pin is ignored here: the synchroniser still shows our own drive
        if (!seq_done) begin
          cnt_nxt = cnt_r - CNT_W'(1);
        end else begin
          state_nxt = ST_RUN;
          flags_nxt = '0;
          if (bidir_act_r) begin
            flags_nxt[FLAG_HW_LONG] = 1'b1;
          end else begin
            unique case (cause_r)
              CAUSE_HW:  flags_nxt[long_r ? FLAG_HW_LONG : FLAG_HW_SHORT] = 1'b1;
              CAUSE_SW:  flags_nxt[FLAG_SW] = 1'b1;
              default:   flags_nxt[FLAG_WDT] = 1'b1;
            endcase
          end
          if ((cause_r == CAUSE_HW || bidir_act_r) && !ea_n_r) begin
            cfg_nxt  = p0_r;
            boot_nxt = ~p0_r[BOOT_BIT];
          end
        end
      end
      default: begin
        state_nxt = ST_SEQ;
        cnt_nxt   = CNT_W'(SEQ_CYCLES - 1);
        cause_nxt = CAUSE_HW;
      end
    endcase
    drive_nxt    = (state_nxt == ST_SEQ) && bidir_act_nxt;
    core_rst_nxt = (state_nxt != ST_RUN);
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_r     <= ST_SEQ;
      cnt_r       <= CNT_W'(SEQ_CYCLES - 1);
      cause_r     <= CAUSE_HW;
      bidir_act_r <= 1'b0;
      bidir_en_r  <= 1'b0;
      init_done_r <= 1'b0;
      long_r      <= 1'b0;
      flags_r     <= '0;
      cfg_r       <= '0;
      boot_r      <= 1'b0;
      drive_r     <= 1'b0;
      core_rst_r  <= 1'b1;
    end else if (clk_en_i) begin
      state_r     <= state_nxt;
      cnt_r       <= cnt_nxt;
      cause_r     <= cause_nxt;
      bidir_act_r <= bidir_act_nxt;
      bidir_en_r  <= bidir_en_nxt;
      init_done_r <= init_done_nxt;
      long_r      <= long_nxt;
      flags_r     <= flags_nxt;
      cfg_r       <= cfg_nxt;
      boot_r      <= boot_nxt;
      drive_r     <= drive_nxt;
      core_rst_r  <= core_rst_nxt;
    end
  end

  // Open drain: only ever drives low
  assign reset_input_pin_o    = 1'b0;
  assign reset_input_pin_oe_o = drive_r;
  assign core_reset_o         = core_rst_r;
  assign bidir_reset_enable_o = bidir_en_r;
  assign init_done_o          = init_done_r;
  assign reset_flags_o        = flags_r;
  assign port_zero_cfg_o      = cfg_r;
  assign boot_loader_o        = boot_r;

endmodule
`default_nettype wire

// [include/brc_pkg.sv]
/*
  Constants for the bidirectional reset controller: timing, flag layout, state codes.
  Assumes a 50 MHz clock on ref_clk_i.
*/
`default_nettype none
package brc_pkg;
  localparam int CLK_PERIOD_NS  = 20;
  localparam int SPIKE_NS       = 10;
  localparam int PASS_NS        = 100;
  // Least times round up, never below one cycle
  localparam int SPIKE_CYC_RAW  = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SPIKE_CYC      = (SPIKE_CYC_RAW < 1) ? 1 : SPIKE_CYC_RAW;
  // Longest time rounds down; the filter must not outlast it
  localparam int PASS_CYC       = PASS_NS / CLK_PERIOD_NS;
  localparam int FILT_CYC       = (SPIKE_CYC > PASS_CYC) ? PASS_CYC : SPIKE_CYC;
  localparam int SEQ_CYC_DEF    = 1024;
  localparam int RELEASE_CYC    = 4;
  localparam int CNT_W          = 16;
  localparam int FILT_W         = 4;
  localparam int CONFIG_SAMPLE_PORT_ZERO_W        = 16;
  localparam int BOOT_BIT       = 4;
  localparam int FLAG_W         = 4;
  localparam int FLAG_HW_LONG   = 0;
  localparam int FLAG_HW_SHORT  = 1;
  localparam int FLAG_SW        = 2;
  localparam int FLAG_WDT       = 3;
  localparam logic [1:0] CAUSE_HW  = 2'h0;
  localparam logic [1:0] CAUSE_SW  = 2'h1;
  localparam logic [1:0] CAUSE_WDT = 2'h2;
  typedef enum logic [3:0] {
    ST_RUN  = 4'b0001,
    ST_SEQ  = 4'b0010,
    ST_HOLD = 4'b0100,
    ST_REL  = 4'b1000
  } brc_state_type;
endpackage
`default_nettype wire

// [verif/brc_reset_ctrl_properties.sv]
/* Port checks for the reset controller.
   Assumes one clock and synchronous active-high reset; checks pause while clk_en_i is low. */
`timescale 1ns/1ns
`default_nettype none
module brc_reset_ctrl_chk (
  input wire logic       ref_clk_i,
  input wire logic       rst_i,
  input wire logic       clk_en_i,
  input wire logic       osc_running_i,
  input wire logic       reset_input_pin_i,
  input wire logic       sw_reset_req_i,
  input wire logic       watchdog_reset_i,
  input wire logic       bidir_enable_wr_i,
  input wire logic       init_done_o,
  input wire logic       reset_input_pin_o,
  input wire logic       reset_input_pin_oe_o,
  input wire logic       core_reset_o,
  input wire logic       bidir_reset_enable_o,
  input wire logic [3:0] reset_flags_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i || !clk_en_i);
  property p_od; reset_input_pin_o == 1'b0; endproperty
  a_od: assert property (p_od) else $error("pin data not low");
  property p_pin; (!reset_input_pin_i && osc_running_i) [*8] |-> ##[0:8] core_reset_o; endproperty
  a_pin: assert property (p_pin) else $error("held pin gave no reset");
  property p_req; !core_reset_o && (sw_reset_req_i || watchdog_reset_i) |-> ##[1:2] core_reset_o; endproperty
  a_req: assert property (p_req) else $error("request gave no reset");
  property p_lock; init_done_o && bidir_enable_wr_i |=> !$rose(bidir_reset_enable_o); endproperty
  a_lock: assert property (p_lock) else $error("locked enable changed");
  property p_clr; $rose(core_reset_o) |-> ##1 !bidir_reset_enable_o; endproperty
  a_clr: assert property (p_clr) else $error("enable kept over reset");
  property p_oe; $rose(core_reset_o) && $past(bidir_reset_enable_o, 2) |-> reset_input_pin_oe_o; endproperty
  a_oe: assert property (p_oe) else $error("pin not driven");
  property p_rel; $fell(reset_input_pin_oe_o) |-> core_reset_o [*3] ##[1:3] !core_reset_o; endproperty
  a_rel: assert property (p_rel) else $error("release guard wrong");
  property p_flag; $fell(reset_input_pin_oe_o) |-> ##[4:6] reset_flags_o == 4'h1; endproperty
  a_flag: assert property (p_flag) else $error("flags not long hw");
  c_bidir: cover property ($rose(reset_input_pin_oe_o));
  c_lock: cover property (init_done_o && bidir_enable_wr_i);
  c_sw: cover property (!core_reset_o && sw_reset_req_i);
endmodule
bind brc_reset_ctrl brc_reset_ctrl_chk brc_reset_ctrl_chk_i (.ref_clk_i, .rst_i, .clk_en_i, .osc_running_i,
  .reset_input_pin_i, .sw_reset_req_i, .watchdog_reset_i, .bidir_enable_wr_i, .init_done_o,
  .reset_input_pin_o, .reset_input_pin_oe_o, .core_reset_o, .bidir_reset_enable_o, .reset_flags_o);
`default_nettype wire

// [verif/brc_ext_reset_model.sv]
/* Outside reset source: open-drain driver on a pulled-up reset line.
   Assumes the device's enable means it pulls the line low. */
`timescale 1ns/1ns
`default_nettype none
module brc_ext_reset_model (
  input  wire logic ref_clk_i,
  input  wire logic oe_i,
  output logic      pin_o
);
  logic pull_r = 1'b0;
  // Wired-low: either party pulls, else the pull-up wins
  assign pin_o = !(pull_r || oe_i);
  task automatic pulse(input int n);
    @(negedge ref_clk_i);
    pull_r = 1'b1;
    repeat (n) @(negedge ref_clk_i);
    pull_r = 1'b0;
  endtask
  task automatic glitch(input int ns);
    @(negedge ref_clk_i);
    pull_r = 1'b1;
    #(ns);
    pull_r = 1'b0;
  endtask
endmodule
`default_nettype wire

// [verif/tb_brc_reset_ctrl.sv]
/* Self-checking bench for the reset controller.
   Assumes the outside model and a short internal sequence. */
`timescale 1ns/1ns
`default_nettype none
module tb_brc_reset_ctrl;
  import brc_pkg::*;
  logic        ref_clk_i = 1'b0, rst_i = 1'b1, osc = 1'b1, sw = 1'b0, wdt = 1'b0;
  localparam int SEQ_T    = 16;
  // About 1 ms of held reset at a 20 ns clock
  localparam int LONG_CYC = 50000;
  logic        eoi = 1'b0, wr = 1'b0, wdata = 1'b0, oe_seen = 1'b0;
  logic        clk_en = 1'b1, ea_n = 1'b0;
  logic [15:0] config_sample_port_zero = 16'hA5E5;
  logic        pin, pin_d, oe, core, en, done, boot;
  logic [3:0]  flags;
  logic [15:0] cfg;
  int          err_total = 0, checks = 0, rst_cyc = 0;
  initial forever #10 ref_clk_i = ~ref_clk_i;
  brc_ext_reset_model brc_ext_reset_model_i (.ref_clk_i(ref_clk_i), .oe_i(oe), .pin_o(pin));
  brc_reset_ctrl #(.SEQ_CYCLES(SEQ_T)) brc_reset_ctrl_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .clk_en_i(clk_en),
    .osc_running_i(osc), .reset_input_pin_i(pin), .ext_access_n_i(ea_n), .config_sample_port_zero_i(config_sample_port_zero),
    .sw_reset_req_i(sw), .watchdog_reset_i(wdt), .end_of_init_instruction_i(eoi), .bidir_enable_wr_i(wr),
    .bidir_enable_wdata_i(wdata), .reset_input_pin_o(pin_d), .reset_input_pin_oe_o(oe), .core_reset_o(core),
    .bidir_reset_enable_o(en), .init_done_o(done), .reset_flags_o(flags), .port_zero_cfg_o(cfg),
    .boot_loader_o(boot));
  always @(posedge ref_clk_i) begin
    if (core) rst_cyc++;
    if (oe) oe_seen = 1'b1;
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Bounded: a hung sequence ends the run instead of stalling it
  task automatic wait_rst(input logic v);
    int n;
    n = 0;
    while (core !== v) begin
      @(negedge ref_clk_i);
      n++;
      if (n > 100) begin
        err_total++;
        close_out;
      end
    end
  endtask
  task automatic strobe(ref logic s);
    @(negedge ref_clk_i);
    s = 1'b1;
    @(negedge ref_clk_i);
    s = 1'b0;
  endtask
  task automatic t_power_on;
    wait_rst(1'b0);
    check(flags, 4'h2, "power-on flags");
    check(cfg, 16'hA5E5, "config");
    check(boot, 1'b1, "boot");
    check(en, 1'b0, "enable");
    $display("power_on done");
  endtask
  task automatic t_sw_wdt;
    config_sample_port_zero = 16'h5A1A;
    strobe(sw);
    wait_rst(1'b1);
    wait_rst(1'b0);
    check(flags, 4'h4, "sw flag");
    check(cfg, 16'hA5E5, "no latch");
    strobe(wdt);
    wait_rst(1'b1);
    wait_rst(1'b0);
    check(flags, 4'h8, "wdt flag");
    $display("sw_wdt done");
  endtask
  task automatic t_bidir;
    wdata = 1'b1;
    strobe(wr);
    check(en, 1'b1, "enable set");
    oe_seen = 1'b0;
    strobe(wdt);
    wait_rst(1'b1);
    wait_rst(1'b0);
    check(oe_seen, 1'b1, "pin driven");
    check(flags, 4'h1, "long flag");
    check(en, 1'b0, "enable cleared");
    check(cfg, 16'h5A1A, "config");
    check(boot, 1'b0, "boot");
    $display("bidir done");
  endtask
  task automatic t_stretch;
    for (int b = 0; b < 2; b++) begin
      wdata = b[0];
      ea_n  = ~b[0];
      config_sample_port_zero = 16'h1234;
      strobe(wr);
      rst_cyc = 0;
      brc_ext_reset_model_i.pulse(8);
      wait_rst(1'b0);
      check(rst_cyc >= SEQ_T, b[0], "stretch");
      check(flags, b[0] ? 4'h1 : 4'h2, "hw flag");
      check(cfg, b[0] ? 16'h1234 : 16'h5A1A, "ea gate");
    end
    $display("stretch done");
  endtask
  task automatic t_refuse;
    rst_cyc = 0;
    brc_ext_reset_model_i.glitch(5);
    osc = 1'b0;
    brc_ext_reset_model_i.pulse(8);
    repeat (10) @(negedge ref_clk_i);
    osc = 1'b1;
    repeat (10) @(negedge ref_clk_i);
    check(rst_cyc == 0, 1'b1, "spurious reset");
    $display("refuse done");
  endtask
  task automatic t_long;
    rst_cyc = 0;
    brc_ext_reset_model_i.pulse(LONG_CYC);
    wait_rst(1'b0);
    check(rst_cyc >= LONG_CYC, 1'b1, "held reset");
    check(flags, 4'h1, "long hw flag");
    $display("long done");
  endtask
  // A frozen block neither takes requests nor advances its sequence
  task automatic t_freeze;
    clk_en = 1'b0;
    strobe(sw);
    repeat (3) @(negedge ref_clk_i);
    check(core, 1'b0, "frozen request");
    clk_en = 1'b1;
    strobe(wdt);
    clk_en = 1'b0;
    repeat (30) @(negedge ref_clk_i);
    check(core, 1'b1, "frozen sequence");
    clk_en = 1'b1;
    wait_rst(1'b0);
    check(flags, 4'h8, "wdt after freeze");
    $display("freeze done");
  endtask
  task automatic t_lock;
    strobe(eoi);
    check(done, 1'b1, "init done");
    wdata = 1'b1;
    strobe(wr);
    check(en, 1'b0, "locked");
    $display("lock done");
  endtask
  initial begin
    repeat (10) @(negedge ref_clk_i);
    rst_i = 1'b0;
    t_power_on;
    t_sw_wdt;
    t_bidir;
    t_stretch;
    t_refuse;
    t_long;
    t_freeze;
    t_lock;
    close_out;
  end
endmodule
`default_nettype wire
